// file: core/qwd_params.svh
// Constants for the queued write deadline and completion block
`ifndef QWD_PARAMS_SVH
`define QWD_PARAMS_SVH

`define QWD_TAGS 32
`define QWD_REM_W 13
`define QWD_DL_COARSE_BIT 7
`define QWD_FMC_BIT 7
`define QWD_CLK_PERIOD_NS 4
`define QWD_FINE_UNIT_NS 10000000
`define QWD_COARSE_UNIT_NS 500000000
`define QWD_FINE_CYC (`QWD_FINE_UNIT_NS / `QWD_CLK_PERIOD_NS)
`define QWD_COARSE_RATIO (`QWD_COARSE_UNIT_NS / `QWD_FINE_UNIT_NS)
`define QWD_TICK_W 22

`endif

// file: core/qwd_pkg.sv
// Types for the queued write deadline and completion block
`include "qwd_params.svh"

package qwd_pkg;

  typedef enum logic [1:0]
  {
    QWD_URG_NORMAL = 2'h0,
    QWD_URG_ISOCH = 2'h1,
    QWD_URG_HIGH = 2'h2,
    QWD_URG_RSVD = 2'h3
  } qwd_urgency_t;

  typedef enum logic [1:0]
  {
    QWD_ST_RUN = 2'b01,
    QWD_ST_HALT = 2'b10
  } qwd_state_t;

  typedef struct packed {
    logic [`QWD_TAGS-1:0] act;
    logic [`QWD_TAGS-1:0] isoch;
    logic [`QWD_TAGS-1:0] fmc;
    logic [`QWD_TAGS-1:0] hiprio;
    logic [`QWD_TAGS-1:0] expd;
    logic [`QWD_TAGS-1:0][`QWD_REM_W-1:0] rem;
    qwd_state_t st;
    logic [47:0] fail_lba;
    logic [47:0] start_lba;
    logic done_v;
    logic [4:0] done_tag;
    logic done_err;
    logic done_abort;
    logic stop_wr;
    logic [7:0] ret_sn;
    logic [7:0] ret_cl;
    logic [7:0] ret_ch;
  } qwd_state_vec_t;

  typedef struct packed {
    logic [`QWD_TICK_W-1:0] cnt;
    logic tick;
  } qwd_tick_state_t;

endpackage : qwd_pkg

// file: core/qwd_tick_gen.sv
// Fine deadline unit tick generator
`include "qwd_params.svh"

module qwd_tick_gen
  import qwd_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `QWD_FINE_CYC
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  output logic tick
);

  qwd_tick_state_t t_r;
  qwd_tick_state_t t_nxt;

  always_comb
  begin
    t_nxt = t_r;
    t_nxt.tick = 1'b0;
    if (t_r.cnt >= `QWD_TICK_W'(TICK_CYCLES - 1))
    begin
      t_nxt.cnt = '0;
      t_nxt.tick = 1'b1;
    end
    else
    begin
      t_nxt.cnt = t_r.cnt + `QWD_TICK_W'(1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      t_r <= '0;
    else if (ce)
      t_r <= t_nxt;
  end

  assign tick = t_r.tick;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_tick_single: assert property (
    TICK_CYCLES > 1 && t_r.tick && ce |=> !t_r.tick)
    else $error("tick lasted more than one enabled cycle");

endmodule : qwd_tick_gen

// file: core/qwd_top.sv
// Queued write deadline timing, completion and failing address return
`include "qwd_params.svh"

module qwd_top
  import qwd_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `QWD_FINE_CYC
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic cmd_accept,
  input wire logic [4:0] cmd_tag,
  input wire logic [1:0] cmd_urgency_class,
  input wire logic [7:0] cmd_completion_deadline_field,
  input wire logic [7:0] cmd_device_head,
  input wire logic [7:0] cmd_sect_num_cur,
  input wire logic [7:0] cmd_sect_num_prev,
  input wire logic [7:0] cmd_cyl_low_cur,
  input wire logic [7:0] cmd_cyl_low_prev,
  input wire logic [7:0] cmd_cyl_high_cur,
  input wire logic [7:0] cmd_cyl_high_prev,
  input wire logic abort_expired_en,
  input wire logic write_cache_en,
  input wire logic [4:0] evt_tag,
  input wire logic evt_xfer_done,
  input wire logic evt_media_done,
  input wire logic evt_unc_error,
  input wire logic [47:0] evt_fail_lba,
  input wire logic high_byte_select,
  output logic [47:0] start_lba,
  output logic [31:0] active_mask,
  output logic [31:0] high_urgency_mask,
  output logic [31:0] expired_mask,
  output logic done_valid,
  output logic [4:0] done_tag,
  output logic done_error,
  output logic done_abort,
  output logic stop_write,
  output logic write_halted,
  output logic [7:0] ret_sector_number,
  output logic [7:0] ret_cyl_low,
  output logic [7:0] ret_cyl_high
);

  // ==========================================================
  // Functions
  function automatic logic [`QWD_REM_W-1:0] dl_ticks(
    input logic [7:0] f
  );
    logic [`QWD_REM_W-1:0] base;
    base = {6'h0, f[6:0]} + `QWD_REM_W'(1);
    if (f[`QWD_DL_COARSE_BIT])
      return `QWD_REM_W'(base * `QWD_REM_W'(`QWD_COARSE_RATIO));
    return base;
  endfunction : dl_ticks

  function automatic logic [4:0] first_set(input logic [31:0] v);
    logic [4:0] idx;
    idx = 5'h0;
    for (int i = 31; i >= 0; i--)
      if (v[i])
        idx = 5'(i);
    return idx;
  endfunction : first_set

  function automatic logic [7:0] ret_byte(
    input logic [47:0] lba,
    input logic hbs,
    input int unsigned idx
  );
    return hbs ? lba[24 + 8*idx +: 8] : lba[8*idx +: 8];
  endfunction : ret_byte

  // ==========================================================
  // State
  qwd_state_vec_t s_r;
  qwd_state_vec_t s_nxt;
  logic tick;
  logic evt_live;
  logic [31:0] overdue;

  qwd_tick_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .tick(tick)
  );

  assign evt_live = s_r.act[evt_tag];
  assign overdue = s_r.act & s_r.expd;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.done_v = 1'b0;
    s_nxt.done_err = 1'b0;
    s_nxt.done_abort = 1'b0;
    s_nxt.stop_wr = 1'b0;
    // Timers only run for isochronous commands
    if (tick)
    begin
      for (int i = 0; i < `QWD_TAGS; i++)
      begin
        if (s_r.act[i] && s_r.isoch[i] && !s_r.expd[i])
        begin
          if (s_r.rem[i] <= `QWD_REM_W'(1))
          begin
            s_nxt.rem[i] = '0;
            s_nxt.expd[i] = 1'b1;
          end
          else
          begin
            s_nxt.rem[i] = s_r.rem[i] - `QWD_REM_W'(1);
          end
        end
      end
    end
    // One completion per cycle; media events beat deadline aborts
    if (evt_unc_error && evt_live)
    begin
      s_nxt.done_v = 1'b1;
      s_nxt.done_tag = evt_tag;
      s_nxt.done_err = 1'b1;
      s_nxt.stop_wr = 1'b1;
      if (s_r.st == QWD_ST_RUN)
      begin
        // Only the first failure since reset or the last command accept is kept for the host to read back
        s_nxt.fail_lba = evt_fail_lba;
        s_nxt.st = QWD_ST_HALT;
      end
    end
    else if (evt_media_done && evt_live)
    begin
      s_nxt.done_v = 1'b1;
      s_nxt.done_tag = evt_tag;
    end
    else if (evt_xfer_done && evt_live && !s_r.fmc[evt_tag]
             && write_cache_en)
    begin
      s_nxt.done_v = 1'b1;
      s_nxt.done_tag = evt_tag;
    end
    else if (abort_expired_en && (|overdue))
    begin
      s_nxt.done_v = 1'b1;
      s_nxt.done_abort = 1'b1;
      s_nxt.done_tag = first_set(overdue);
    end
    // Overdue commands with abort off simply stay active
    if (s_nxt.done_v)
    begin
      s_nxt.act[s_nxt.done_tag] = 1'b0;
      s_nxt.isoch[s_nxt.done_tag] = 1'b0;
      s_nxt.hiprio[s_nxt.done_tag] = 1'b0;
      s_nxt.expd[s_nxt.done_tag] = 1'b0;
      s_nxt.rem[s_nxt.done_tag] = '0;
    end
    if (cmd_accept)
    begin
      s_nxt.act[cmd_tag] = 1'b1;
      s_nxt.expd[cmd_tag] = 1'b0;
      s_nxt.isoch[cmd_tag] = (cmd_urgency_class == QWD_URG_ISOCH);
      s_nxt.hiprio[cmd_tag] = (cmd_urgency_class == QWD_URG_HIGH);
      s_nxt.fmc[cmd_tag] = cmd_device_head[`QWD_FMC_BIT];
      s_nxt.rem[cmd_tag] = (cmd_urgency_class == QWD_URG_ISOCH) ?
        dl_ticks(cmd_completion_deadline_field) : '0;
      s_nxt.start_lba = {cmd_cyl_high_prev, cmd_cyl_low_prev,
        cmd_sect_num_prev, cmd_cyl_high_cur, cmd_cyl_low_cur,
        cmd_sect_num_cur};
      s_nxt.st = QWD_ST_RUN;
    end
    case (s_r.st)
      QWD_ST_RUN, QWD_ST_HALT:
      begin
        s_nxt.ret_sn = ret_byte(s_r.fail_lba, high_byte_select, 0);
        s_nxt.ret_cl = ret_byte(s_r.fail_lba, high_byte_select, 1);
        s_nxt.ret_ch = ret_byte(s_r.fail_lba, high_byte_select, 2);
      end
      default:
      begin
        s_nxt.st = QWD_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_r <= '0;
      s_r.st <= QWD_ST_RUN;
    end
    else if (ce)
    begin
      s_r <= s_nxt;
    end
  end

  assign start_lba = s_r.start_lba;
  assign active_mask = s_r.act;
  assign high_urgency_mask = s_r.hiprio;
  assign expired_mask = s_r.expd;
  assign done_valid = s_r.done_v;
  assign done_tag = s_r.done_tag;
  assign done_error = s_r.done_err;
  assign done_abort = s_r.done_abort;
  assign stop_write = s_r.stop_wr;
  assign write_halted = (s_r.st == QWD_ST_HALT);
  assign ret_sector_number = s_r.ret_sn;
  assign ret_cyl_low = s_r.ret_cl;
  assign ret_cyl_high = s_r.ret_ch;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence unc_first;
    ce && evt_unc_error && evt_live && s_r.st == QWD_ST_RUN;
  endsequence

  sequence read_low;
    ce && !high_byte_select;
  endsequence

  sequence read_high;
    ce && high_byte_select;
  endsequence

  a_fine_load: assert property (
    ce && cmd_accept && cmd_urgency_class == QWD_URG_ISOCH
    && !cmd_completion_deadline_field[7]
    |=> s_r.rem[$past(cmd_tag)] ==
        13'($past(cmd_completion_deadline_field[6:0])) + 13'd1)
    else $error("fine deadline loaded wrong");

  a_coarse_load: assert property (
    ce && cmd_accept && cmd_urgency_class == QWD_URG_ISOCH
    && cmd_completion_deadline_field[7]
    |=> s_r.rem[$past(cmd_tag)] ==
        (13'($past(cmd_completion_deadline_field[6:0])) + 13'd1) * 13'd50)
    else $error("coarse deadline loaded wrong");

  a_isoch_only: assert property (
    (s_r.expd & ~s_r.isoch) == 32'h0000_0000)
    else $error("non-isochronous command marked overdue");

  a_abort_gate: assert property (
    ce && !abort_expired_en |=> !s_r.done_abort)
    else $error("deadline abort while abort disabled");

  a_fua_media: assert property (
    ce && evt_xfer_done && !evt_media_done && !evt_unc_error && evt_live
    && s_r.fmc[evt_tag] |=> !(s_r.done_v && !s_r.done_abort
    && s_r.done_tag == $past(evt_tag)))
    else $error("forced commit completed before media");

  a_early_cmp: assert property (
    ce && evt_xfer_done && !evt_media_done && !evt_unc_error && evt_live
    && !s_r.fmc[evt_tag] && write_cache_en
    |=> s_r.done_v && s_r.done_tag == $past(evt_tag))
    else $error("cached write not completed on transfer");

  a_ret_low: assert property (
    unc_first ##1 read_low |=>
    {s_r.ret_ch, s_r.ret_cl, s_r.ret_sn} == $past(evt_fail_lba[23:0], 2))
    else $error("low failing address bytes wrong");

  a_ret_high: assert property (
    unc_first ##1 read_high |=>
    {s_r.ret_cl, s_r.ret_sn} == $past(evt_fail_lba[39:24], 2))
    else $error("upper failing address bytes wrong");

  a_ret_top: assert property (
    unc_first ##1 read_high |=> s_r.ret_ch == $past(evt_fail_lba[47:40], 2))
    else $error("top failing address byte wrong");

  a_stop_write: assert property (
    unc_first |=> s_r.stop_wr && s_r.done_err && write_halted)
    else $error("write not stopped at failing block");

  a_high_mask: assert property (
    (s_r.hiprio & ~s_r.act) == 32'h0000_0000)
    else $error("high urgency flag on idle tag");

endmodule : qwd_top

// file: testbench/queued_write_deadline_params_tb_top.sv
// Testbench for the queued write deadline block
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end

module queued_write_deadline_params_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic abort_en = 1'b0;
  logic cache_en = 1'b1;
  logic hbs = 1'b0;
  logic [4:0] evt_tag = 5'h00;
  logic [2:0] evt_k = 3'h0;
  logic [47:0] evt_lba = '0;
  logic acc, fv, de, da, sw, wh;
  logic [4:0] ctag, dtag;
  logic [1:0] urg;
  logic [7:0] fld, dh, rsn, rcl, rch;
  logic [5:0][7:0] lb;
  logic [47:0] slba;
  logic [31:0] act, hi, exp_m;
  int mismatches = 0;
  int compares = 0;

  initial
  begin
    forever #2 clk = ~clk;
  end

  qwd_host_model host (.clk(clk), .cmd_accept(acc), .cmd_tag(ctag),
    .cmd_urgency_class(urg), .cmd_completion_deadline_field(fld),
    .cmd_device_head(dh), .lba_bytes(lb));

  qwd_top #(.TICK_CYCLES(4)) DUT (.clk(clk), .rst_n(rst_n), .ce(ce),
    .cmd_accept(acc), .cmd_tag(ctag), .cmd_urgency_class(urg),
    .cmd_completion_deadline_field(fld), .cmd_device_head(dh),
    .cmd_sect_num_cur(lb[0]), .cmd_sect_num_prev(lb[1]),
    .cmd_cyl_low_cur(lb[2]), .cmd_cyl_low_prev(lb[3]),
    .cmd_cyl_high_cur(lb[4]), .cmd_cyl_high_prev(lb[5]),
    .abort_expired_en(abort_en), .write_cache_en(cache_en),
    .evt_tag(evt_tag), .evt_xfer_done(evt_k[0]), .evt_media_done(evt_k[1]),
    .evt_unc_error(evt_k[2]), .evt_fail_lba(evt_lba),
    .high_byte_select(hbs), .start_lba(slba), .active_mask(act),
    .high_urgency_mask(hi), .expired_mask(exp_m), .done_valid(fv),
    .done_tag(dtag), .done_error(de), .done_abort(da), .stop_write(sw),
    .write_halted(wh), .ret_sector_number(rsn), .ret_cyl_low(rcl),
    .ret_cyl_high(rch));

  // ==========================================
  // Access tasks
  task conclude;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude

  task evt(input logic [4:0] t, input logic [2:0] k, input logic [47:0] a);
    @(posedge clk);
    evt_tag <= t;
    evt_k <= k;
    evt_lba <= a;
    @(posedge clk);
    evt_k <= 3'h0;
    evt_lba <= ~a;
    #1;
  endtask : evt

  // Cycles from now until the tag's deadline flag rises
  task wait_exp(input int t, input int lo, input int hi_b);
    int n;
    n = 0;
    while (exp_m[t] !== 1'b1)
    begin
      if (n > hi_b)
      begin
        mismatches++;
        conclude();
      end
      @(posedge clk);
      #1;
      n++;
    end
    `CHK(n >= lo && n <= hi_b, 1'b1)
  endtask : wait_exp

  task wait_done;
    int n;
    n = 0;
    while (fv !== 1'b1)
    begin
      if (n > 20)
      begin
        mismatches++;
        conclude();
      end
      @(posedge clk);
      #1;
      n++;
    end
  endtask : wait_done

  // ==========================================
  // Scenarios
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    host.issue(5'h01, 2'h0, 8'h00, 1'b0, 48'h0102_0304_0506);
    `CHK(slba, 48'h0102_0304_0506)
    host.issue(5'h02, 2'h2, 8'h00, 1'b0, 48'hA5A5_5A5A_0FF0);
    `CHK(hi[2:1], 2'h2)
    host.issue(5'h03, 2'h1, 8'h80, 1'b0, 48'h0);
    host.issue(5'h04, 2'h1, 8'h01, 1'b0, 48'h0);
    wait_exp(4, 4, 14);
    `CHK(exp_m[3], 1'b0)
    wait_exp(3, 170, 205);
    `CHK(exp_m[1], 1'b0)
    `CHK(act[4:3], 2'h3)
    @(posedge clk);
    abort_en <= 1'b1;
    wait_done();
    `CHK({da, dtag}, 6'h23)
    @(posedge clk);
    #1;
    wait_done();
    `CHK({da, dtag}, 6'h24)
    @(posedge clk);
    abort_en <= 1'b0;
    host.issue(5'h05, 2'h0, 8'h00, 1'b1, 48'h0);
    evt(5'h05, 3'h1, 48'h0);
    `CHK(fv, 1'b0)
    evt(5'h05, 3'h2, 48'h0);
    `CHK({fv, dtag}, 6'h25)
    host.issue(5'h06, 2'h0, 8'h00, 1'b0, 48'h0);
    evt(5'h06, 3'h1, 48'h0);
    `CHK({fv, dtag, act[6]}, 7'h4C)
    evt(5'h01, 3'h4, 48'hA1B2_C3D4_E5F6);
    `CHK({de, sw, wh, dtag}, 8'hE1)
    @(posedge clk);
    #1;
    `CHK({rch, rcl, rsn}, 24'hD4_E5F6)
    @(posedge clk);
    hbs <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    `CHK({rch, rcl, rsn}, 24'hA1_B2C3)
    host.issue(5'h07, 2'h0, 8'h00, 1'b0, 48'h0);
    `CHK(wh, 1'b0)
    @(posedge clk);
    cache_en <= 1'b0;
    evt(5'h07, 3'h1, 48'h0);
    `CHK(fv, 1'b0)
    evt(5'h07, 3'h4, 48'h1122_3344_5566);
    `CHK({de, dtag}, 6'h27)
    @(posedge clk);
    #1;
    `CHK({rch, rcl, rsn}, 24'h11_2233)
    @(posedge clk);
    ce <= 1'b0;
    host.issue(5'h08, 2'h2, 8'h00, 1'b0, 48'h0);
    `CHK(act[8], 1'b0)
    @(posedge clk);
    ce <= 1'b1;
    conclude();
  end
endmodule : queued_write_deadline_params_tb_top

// file: testbench/qwd_host_model.sv
// Host controller model issuing queued write commands
module qwd_host_model
(
  input wire logic clk,
  output logic cmd_accept,
  output logic [4:0] cmd_tag,
  output logic [1:0] cmd_urgency_class,
  output logic [7:0] cmd_completion_deadline_field,
  output logic [7:0] cmd_device_head,
  output logic [5:0][7:0] lba_bytes
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    cmd_accept = 1'b0;
    cmd_tag = 5'h00;
    cmd_urgency_class = 2'h0;
    cmd_completion_deadline_field = 8'h00;
    cmd_device_head = 8'h00;
    lba_bytes = '0;
  end

  // ==========================================
  // Command issue
  // Caller keeps tags unique while in flight
  task issue(input logic [4:0] t, input logic [1:0] u, input logic [7:0] f,
             input logic fmc, input logic [47:0] a);
    @(posedge clk);
    cmd_accept <= 1'b1;
    cmd_tag <= t;
    cmd_urgency_class <= u;
    cmd_completion_deadline_field <= f;
    cmd_device_head <= {fmc, 7'h40};
    // Byte order: sn cur/prev, cl cur/prev, ch cur/prev
    lba_bytes <= {a[47:40], a[23:16], a[39:32],
                  a[15:8], a[31:24], a[7:0]};
    @(posedge clk);
    cmd_accept <= 1'b0;
    // Released deadline and LBA fields show garbage; tag, urgency and device head keep the last value
    cmd_completion_deadline_field <= ~f;
    lba_bytes <= ~lba_bytes;
    #1;
  endtask : issue
endmodule : qwd_host_model
